//--- logic/bsns_core.sv
`timescale 1ns/100ps
// Sequencer for the two instructions over four phases on sys_clk.
module bsns_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [bsns_pkg::BANK_W-1:0] bank_select_reg,
  input wire logic [7:0] wreg_in,
  input wire logic [4:0] flags_in,
  input wire logic [7:0] file_rdata,
  output logic busy,
  output logic illegal,
  output logic done,
  output logic file_rd,
  output logic [bsns_pkg::ADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic wreg_we,
  output logic [7:0] wreg_out,
  output logic flags_we,
  output logic [4:0] flags_out
);
  import bsns_pkg::*;

  // Sequencer state: phase, the decoded word, its address and the source.
  bsns_phase_e phase_r, phase_nxt;
  logic busy_r, busy_nxt;
  logic subb_r, subb_nxt;
  logic dest_r, dest_nxt;
  logic illegal_r, illegal_nxt;
  logic rd_r, rd_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0] src_r, src_nxt;

  // Write-back state: results, flags and the one-cycle strobes.
  logic [7:0] fw_r, fw_nxt;
  logic [7:0] ww_r, ww_nxt;
  logic [4:0] fl_r, fl_nxt;
  logic fwe_r, fwe_nxt;
  logic wwe_r, wwe_nxt;
  logic flwe_r, flwe_nxt;
  logic done_r, done_nxt;

  // Arithmetic unit outputs and the decode-phase acceptance term.
  logic [7:0] alu_res;
  logic [4:0] alu_flags;
  logic take_word;

  // Opcode field of an instruction word.
  function automatic logic [5:0] op_field(input logic [15:0] word);
    return word[15:OPC_LSB];
  endfunction

  // Opcode recognition.
  // Only the two exact six-bit patterns pass; their neighbours are foreign.
  function automatic logic is_known_op(input logic [15:0] word);
    return (op_field(word) == OPC_SUBB) || (op_field(word) == OPC_SWAP);
  endfunction

  // Bank choice.
  // With the bank bit clear the access bank is used: low offsets go to the
  // bottom bank and high offsets to the top one, so the bank select register
  // never has to be reloaded to reach either half.
  function automatic logic [ADDR_W-1:0] file_address(
    input logic [15:0] word,
    input logic [BANK_W-1:0] bank
  );
    logic [BANK_W-1:0] page;
    if (word[BANK_BIT]) begin
      page = bank;
    end else if (word[7:0] < ACCESS_SPLIT) begin
      page = ACCESS_BANK_LO;
    end else begin
      page = ACCESS_BANK_HI;
    end
    return {page, word[7:0]};
  endfunction

  // The unit works on the latched source byte and the live working register.
  bsns_alu u_alu (
    .src(src_r),
    .wreg(wreg_in),
    .flags_in(flags_in),
    .is_subb(subb_r),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  // Words offered while an instruction runs are ignored, not queued.
  assign take_word = instr_valid && (phase_r == BSNS_Q1_DECODE);

  // Sequencer next state; a new word is only taken while idle in Q1.
  always_comb begin
    phase_nxt = phase_r;
    busy_nxt = busy_r;
    subb_nxt = subb_r;
    dest_nxt = dest_r;
    addr_nxt = addr_r;
    src_nxt = src_r;
    illegal_nxt = 1'b0;
    rd_nxt = 1'b0;
    case (phase_r)
      BSNS_Q1_DECODE: begin
        if (take_word) begin
          if (is_known_op(instr_word)) begin
            subb_nxt = (op_field(instr_word) == OPC_SUBB);
            dest_nxt = instr_word[DEST_BIT];
            addr_nxt = file_address(instr_word, bank_select_reg);
            busy_nxt = 1'b1;
            rd_nxt = 1'b1;
            phase_nxt = BSNS_Q2_READ;
          end else begin
            // A foreign word is flagged and dropped; no file access follows.
            illegal_nxt = 1'b1;
          end
        end
      end
      BSNS_Q2_READ: begin
        // The file data stood during the read strobe cycle.
        src_nxt = file_rdata;
        phase_nxt = BSNS_Q3_PROC;
      end
      BSNS_Q3_PROC: begin
        phase_nxt = BSNS_Q4_WRITE;
      end
      BSNS_Q4_WRITE: begin
        // Busy drops with the write so the next word can be taken at once.
        busy_nxt = 1'b0;
        phase_nxt = BSNS_Q1_DECODE;
      end
      default: begin
        phase_nxt = BSNS_Q1_DECODE;
      end
    endcase
  end

  // Write-back next state; results are captured in Q3 and strobed in Q4.
  always_comb begin
    fw_nxt = fw_r;
    ww_nxt = ww_r;
    fl_nxt = fl_r;
    fwe_nxt = 1'b0;
    wwe_nxt = 1'b0;
    flwe_nxt = 1'b0;
    done_nxt = 1'b0;
    case (phase_r)
      BSNS_Q3_PROC: begin
        // Both destinations see the result; only one strobe will fire.
        fw_nxt = alu_res;
        ww_nxt = alu_res;
        fl_nxt = alu_flags;
      end
      BSNS_Q4_WRITE: begin
        fwe_nxt = dest_r;
        wwe_nxt = ~dest_r;
        flwe_nxt = subb_r;
        done_nxt = 1'b1;
      end
      default: begin
        // Decode and read leave the write-back state alone.
        done_nxt = 1'b0;
      end
    endcase
  end

  // Sequencer registers; reset returns to an idle decode phase.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r <= BSNS_Q1_DECODE;
      busy_r <= 1'b0;
      subb_r <= 1'b0;
      dest_r <= 1'b0;
      addr_r <= '0;
      src_r <= RESET_DATA;
      illegal_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      busy_r <= busy_nxt;
      subb_r <= subb_nxt;
      dest_r <= dest_nxt;
      addr_r <= addr_nxt;
      src_r <= src_nxt;
      illegal_r <= illegal_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Write-back registers; a reset in mid-instruction drops any pending write.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fw_r <= RESET_DATA;
      ww_r <= RESET_DATA;
      fl_r <= RESET_FLAGS;
      fwe_r <= 1'b0;
      wwe_r <= 1'b0;
      flwe_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      fw_r <= fw_nxt;
      ww_r <= ww_nxt;
      fl_r <= fl_nxt;
      fwe_r <= fwe_nxt;
      wwe_r <= wwe_nxt;
      flwe_r <= flwe_nxt;
      done_r <= done_nxt;
    end
  end

  // Every output is taken straight from its register.
  assign busy = busy_r;
  assign illegal = illegal_r;
  assign done = done_r;
  assign file_rd = rd_r;
  assign file_addr = addr_r;
  assign file_we = fwe_r;
  assign file_wdata = fw_r;
  assign wreg_we = wwe_r;
  assign wreg_out = ww_r;
  assign flags_we = flwe_r;
  assign flags_out = fl_r;
endmodule

//--- logic/bsns_pkg.sv
package bsns_pkg;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam logic [5:0] OPC_SUBB = 6'h16;
  localparam logic [5:0] OPC_SWAP = 6'h0E;
  localparam int OPC_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int FLAG_N = 4;
  localparam int FLAG_OV = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_DC = 1;
  localparam int FLAG_C = 0;
  localparam logic [BANK_W-1:0] ACCESS_BANK_LO = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_BANK_HI = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [7:0] RESET_DATA = 8'h00;
  localparam logic [4:0] RESET_FLAGS = 5'h00;
  typedef enum logic [1:0] {
    BSNS_Q1_DECODE, BSNS_Q2_READ, BSNS_Q3_PROC, BSNS_Q4_WRITE
  } bsns_phase_e;
endpackage

//--- logic/bsns_alu.sv
`timescale 1ns/100ps
// Combinational arithmetic for the two instructions.
module bsns_alu (
  input wire logic [7:0] src,
  input wire logic [7:0] wreg,
  input wire logic [4:0] flags_in,
  input wire logic is_subb,
  output logic [7:0] result,
  output logic [4:0] flags_out
);
  import bsns_pkg::*;
  logic [8:0] diff;
  logic [4:0] low;
  logic borrow_in;

  // Two's complement subtraction; carry set means no borrow occurred.
  always_comb begin
    borrow_in = ~flags_in[FLAG_C];
    diff = {1'b0, src} + {1'b0, ~wreg} + {8'h00, ~borrow_in};
    low = {1'b0, src[3:0]} + {1'b0, ~wreg[3:0]} + {4'h0, ~borrow_in};
    flags_out = flags_in;
    if (is_subb) begin
      result = diff[7:0];
      flags_out[FLAG_C] = diff[8];
      flags_out[FLAG_DC] = low[4];
      flags_out[FLAG_Z] = (diff[7:0] == 8'h00);
      flags_out[FLAG_N] = diff[7];
      flags_out[FLAG_OV] = (src[7] != wreg[7]) && (diff[7] != src[7]);
    end else begin
      result = {src[3:0], src[7:4]};
    end
  end
endmodule

//--- tb/bsns_props.sv
`timescale 1ns/100ps
// Port checks; decode and bank choice are judged against the taken word.
module bsns_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [bsns_pkg::BANK_W-1:0] bank_select_reg,
  input wire logic busy,
  input wire logic illegal,
  input wire logic done,
  input wire logic file_rd,
  input wire logic [bsns_pkg::ADDR_W-1:0] file_addr,
  input wire logic file_we,
  input wire logic flags_we
);
  import bsns_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [5:0] op = instr_word[15:10];
  wire logic ok = op == OPC_SUBB || op == OPC_SWAP;
  a_read_after_take:
    assert property (instr_valid && !busy && ok |=> file_rd)
    else $error("no read after take");
  a_write_phase:
    assert property (file_rd |-> !done [*3] ##1 done)
    else $error("write not in fourth cycle");
  a_refuse_other:
    assert property (instr_valid && !busy && !ok |=> illegal && !file_rd)
    else $error("foreign word not refused");
  a_bank_choice:
    assert property (file_rd |-> file_addr == {$past(instr_word[8]) ?
      $past(bank_select_reg) : ($past(instr_word[7]) ? 4'hF : 4'h0),
      $past(instr_word[7:0])}) else $error("wrong file address");
  a_dest_select:
    assert property (done |-> file_we == $past(instr_word[9], 4))
    else $error("wrong destination");
  a_flag_update:
    assert property (done |-> flags_we == ($past(op, 4) == OPC_SUBB))
    else $error("wrong flag strobe");
  a_done_pulse:
    assert property (done |=> !done)
    else $error("done longer than one cycle");
endmodule
bind bsns_core bsns_props u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr_word(instr_word), .bank_select_reg(bank_select_reg),
  .busy(busy), .illegal(illegal), .done(done), .file_rd(file_rd),
  .file_addr(file_addr), .file_we(file_we), .flags_we(flags_we)
);

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import bsns_pkg::*;
  logic sys_clk = 0, rst_n = 0, instr_valid = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_reg = 4'h5;
  logic [7:0] wreg_in = 8'h00, file_rdata = 8'h00;
  logic [4:0] flags_in = 5'h00;
  logic busy, illegal, done, file_rd, file_we, wreg_we, flags_we;
  logic [ADDR_W-1:0] file_addr;
  logic [7:0] file_wdata, wreg_out;
  logic [4:0] flags_out;
  int fail_count = 0, compares = 0;
  always #12.5 sys_clk = ~sys_clk;
  bsns_core uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .bank_select_reg(bank_select_reg),
    .wreg_in(wreg_in), .flags_in(flags_in), .file_rdata(file_rdata),
    .busy(busy), .illegal(illegal), .done(done), .file_rd(file_rd),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .wreg_we(wreg_we), .wreg_out(wreg_out), .flags_we(flags_we),
    .flags_out(flags_out)
  );
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One instruction; file data stays valid through the read cycle.
  task automatic run(input logic [5:0] op, input logic d, a,
      input logic [7:0] f, rd, w, input logic [4:0] fl, ef,
      input logic [7:0] er);
    int i;
    @(posedge sys_clk) #1;
    instr_valid = 1;
    instr_word = {op, d, a, f};
    file_rdata = rd;
    wreg_in = w;
    flags_in = fl;
    @(posedge sys_clk) #1;
    instr_valid = 0;
    chk(file_rd, 1'b1);
    chk(busy, 1'b1);
    chk(file_addr, {a ? 4'h5 : (f[7] ? 4'hF : 4'h0), f});
    for (i = 0; i < 8 && done !== 1'b1; i++)
      @(posedge sys_clk) #1;
    chk(16'(i), 16'h0003);
    if (i == 8)
      final_report;
    chk({file_we, wreg_we}, {d, !d});
    chk(d ? file_wdata : wreg_out, er);
    chk(flags_we, op == OPC_SUBB);
    if (op == OPC_SUBB)
      chk(flags_out, ef);
    chk(busy, 1'b0);
    @(posedge sys_clk) #1;
    chk({done, file_we, wreg_we, flags_we}, 4'h0);
  endtask
  // Reset cuts an instruction short; no write may follow it.
  task automatic sc_reset;
    @(posedge sys_clk) #1;
    instr_valid = 1;
    instr_word = {OPC_SUBB, 2'b11, 8'h20};
    @(posedge sys_clk) #1;
    instr_valid = 0;
    rst_n = 0;
    @(posedge sys_clk) #1;
    rst_n = 1;
    chk({busy, file_rd, done, file_we, wreg_we}, 5'h00);
    repeat (4) begin
      @(posedge sys_clk) #1;
      chk({done, file_we, wreg_we, flags_we}, 4'h0);
    end
  endtask
  // Borrow is the inverted carry; flags {N,OV,Z,DC,C}.
  task automatic sc_sub(input logic d, a, input logic [7:0] f, r, w,
      input logic c);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, r} - {1'b0, w} - {8'h00, !c};
    h = {1'b0, r[3:0]} - {1'b0, w[3:0]} - {4'h0, !c};
    run(OPC_SUBB, d, a, f, r, w, {4'hA, c}, {t[7], r[7] != w[7] &&
      t[7] != r[7], t[7:0] == 8'h00, !h[4], !t[8]}, t[7:0]);
  endtask
  task automatic sc_swap(input logic d, a, input logic [7:0] f, r);
    run(OPC_SWAP, d, a, f, r, 8'h3C, 5'h15, 5'h00, {r[3:0], r[7:4]});
  endtask
  // A neighbouring opcode must be refused without a file read.
  task automatic sc_illegal;
    @(posedge sys_clk) #1;
    instr_valid = 1;
    instr_word = 16'h5C12;
    @(posedge sys_clk) #1;
    instr_valid = 0;
    chk({illegal, file_rd}, 2'b10);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1;
    sc_sub(1'b1, 1'b0, 8'h20, 8'h19, 8'h0D, 1'b1);
    sc_sub(1'b0, 1'b1, 8'h90, 8'h1B, 8'h1A, 1'b0);
    sc_sub(1'b1, 1'b0, 8'hA0, 8'h03, 8'h0E, 1'b1);
    sc_sub(1'b0, 1'b1, 8'h7F, 8'h80, 8'h01, 1'b1);
    sc_swap(1'b1, 1'b0, 8'h45, 8'h53);
    sc_swap(1'b0, 1'b1, 8'hC3, 8'hA6);
    sc_illegal;
    sc_reset;
    sc_swap(1'b1, 1'b1, 8'h10, 8'h0F);
    final_report;
  end
endmodule
